// File: urb_sci.sv
// serial receiver with baud generation, parity, muting and a small transmitter
// assumes APB master on clk, rxd synchronous to clk, ce freezes everything
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
module urb_sci
    import urb_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial line
    input  wire logic        rxd,
    output logic             txd,
    // interrupt request
    output logic             irq
);
    logic [7:0]    cr1_r;
    logic [7:0]    cr2_r;
    logic [7:0]    baud_r;
    logic [7:0]    rxfine_r;
    logic [7:0]    txfine_r;
    logic [7:0]    data_r;
    logic          r8_r;
    logic          tc_r;
    logic          sr_seen_r;
    logic          idle_arm_r;
    urb_flags_type flg_r;

    // divide value of one direction: prescaler x fine x 2^sel
    function automatic logic [18:0] div_of(input logic [1:0] ps_sel,
                                           input logic [7:0] fine,
                                           input logic [2:0] dsel);
        logic [18:0] pr;
        logic [18:0] f;
        case (ps_sel)
            2'h0:    pr = PR_0;
            2'h1:    pr = PR_1;
            2'h2:    pr = PR_2;
            default: pr = PR_3;
        endcase
        f = (fine == 8'h00) ? 19'h00001 : {11'h000, fine};
        return 19'((pr * f) << dsel);
    endfunction

    // xor of 8 or 9 bits depending on word length
    function automatic logic par_of(input logic [8:0] w, input logic m);
        return m ? ^w : ^w[7:0];
    endfunction

    // decoded control bits
    logic m;
    logic wake;
    logic parity_enable;
    logic ps;
    logic mute;
    logic scid;
    assign m    = cr1_r[CR1_M];
    assign wake = cr1_r[CR1_WAKE];
    assign parity_enable  = cr1_r[CR1_PCE];
    assign ps   = cr1_r[CR1_PS];
    assign scid = cr1_r[CR1_SCID];
    assign mute = cr2_r[CR2_RWU];

    // apb decode
    logic       acc;
    logic       hit;
    logic [7:0] rd_mux;
    logic       tx_busy_r;
    logic       wr_cr2;
    logic       wr_dat;
    logic       rd_st;
    logic       rd_dat_clr;
    assign acc        = psel & penable & pready;
    assign wr_cr2     = acc & pwrite & (paddr == ADDR_CR2);
    assign wr_dat     = acc & pwrite & (paddr == ADDR_DATA);
    assign rd_st      = acc & ~pwrite & (paddr == ADDR_STATUS);
    assign rd_dat_clr = acc & ~pwrite & (paddr == ADDR_DATA) & sr_seen_r;

    // read mux
    always_comb begin
        hit    = 1'b1;
        rd_mux = 8'h00;
        case (paddr)
            ADDR_STATUS: rd_mux = {~tx_busy_r, tc_r, flg_r.rx_full_flag, flg_r.idle,
                                   flg_r.ovr, flg_r.nf, flg_r.fe, flg_r.pe};
            ADDR_DATA:   rd_mux = data_r;
            ADDR_BAUD:   rd_mux = baud_r;
            ADDR_CR1:    rd_mux = {r8_r, cr1_r[6:0]};
            ADDR_CR2:    rd_mux = cr2_r;
            ADDR_RXFINE: rd_mux = rxfine_r;
            ADDR_TXFINE: rd_mux = txfine_r;
            default:     hit = 1'b0;
        endcase
    end

    // one wait state so read data leaves a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= 1'b0;
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                prdata  <= {24'h000000, rd_mux};
                pslverr <= ~hit;
            end
        end
    end

    // plain configuration registers; baud values are not retimed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr1_r    <= RST_CTRL;
            baud_r   <= RST_BAUD;
            rxfine_r <= RST_FINE;
            txfine_r <= RST_FINE;
        end else if (ce && acc && pwrite) begin
            case (paddr)
                ADDR_CR1:    cr1_r    <= pwdata[7:0];
                ADDR_BAUD:   baud_r   <= pwdata[7:0];
                ADDR_RXFINE: rxfine_r <= pwdata[7:0];
                ADDR_TXFINE: txfine_r <= pwdata[7:0];
                default:     cr1_r    <= cr1_r;
            endcase
        end
    end

    // status-then-data sequence tracker
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_seen_r <= 1'b0;
        end else if (ce) begin
            if (rd_st) begin
                sr_seen_r <= 1'b1;
            end else if (acc && paddr == ADDR_DATA) begin
                sr_seen_r <= 1'b0;
            end
        end
    end

    // receive oversampling clock: 16 ticks per bit
    logic [18:0] rx_div;
    logic [18:0] rx_pc_r;
    logic        rx_tick;
    assign rx_div  = div_of(baud_r[BAUD_PR+:2], rxfine_r, baud_r[BAUD_RX+:3]);
    assign rx_tick = cr2_r[CR2_RE] & ~scid & (rx_pc_r == 19'h00000);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_pc_r <= 19'h00000;
        end else if (ce && !cr2_r[CR2_RE]) begin
            rx_pc_r <= 19'h00000; // restart so a new baud setting ticks at once
        end else if (ce && !scid) begin
            rx_pc_r <= (rx_pc_r == 19'h00000) ? rx_div - 19'h00001 : rx_pc_r - 19'h00001;
        end
    end

    // receive sequencer
    urb_rxst_type rx_st_r;
    logic [3:0]   scnt_r;
    logic [2:0]   smp_r;
    logic [2:0]   hist_r;
    logic         edge_bad_r;
    logic         nz_r;
    logic         hid_nf_r;
    logic [3:0]   bcnt_r;
    logic [8:0]   sh_r;
    logic         done_r;
    logic         dfe_r;
    logic         dnf_r;
    logic [7:0]   idle_cnt_r;
    logic         idle_evt_r;
    logic         maj;
    logic         noisy;
    logic [7:0]   idle_len;
    logic [3:0]   nbits;
    logic [8:0]   rx_word;
    logic         msb;
    logic         am_wake;
    logic         accept;
    logic         idle_wake;

    assign maj      = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
    assign noisy    = ~((smp_r[0] == smp_r[1]) && (smp_r[1] == smp_r[2]));
    assign idle_len = m ? IDLE_M1 : IDLE_M0;
    assign nbits    = m ? DBITS_M1 : DBITS_M0;
    assign rx_word  = m ? sh_r : {1'b0, sh_r[8:1]};
    // with parity on, the parity bit sits at the top and is skipped for the address mark
    assign msb      = m ? (parity_enable ? rx_word[7] : rx_word[8]) : (parity_enable ? rx_word[6] : rx_word[7]);
    assign am_wake  = done_r & mute & wake & msb;
    assign accept   = done_r & (~mute | am_wake);
    assign idle_wake = idle_evt_r & mute & ~wake;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_r    <= RX_HUNT;
            scnt_r     <= 4'h0;
            smp_r      <= 3'h7;
            hist_r     <= 3'h0;
            edge_bad_r <= 1'b0;
            nz_r       <= 1'b0;
            hid_nf_r   <= 1'b0;
            bcnt_r     <= 4'h0;
            sh_r       <= 9'h000;
            done_r     <= 1'b0;
            dfe_r      <= 1'b0;
            dnf_r      <= 1'b0;
            idle_cnt_r <= 8'h00;
            idle_evt_r <= 1'b0;
        end else if (ce) begin
            done_r     <= 1'b0;
            idle_evt_r <= 1'b0;
            if (accept) begin
                hid_nf_r <= 1'b0;
            end
            if (!cr2_r[CR2_RE]) begin
                rx_st_r    <= RX_HUNT;
                hist_r     <= 3'h0;
                idle_cnt_r <= 8'h00;
            end else if (rx_tick) begin
                case (rx_st_r)
                    RX_HUNT: begin
                        hist_r <= {hist_r[1:0], rxd};
                        if (!rxd) begin
                            rx_st_r    <= RX_START;
                            scnt_r     <= 4'h1;
                            edge_bad_r <= (hist_r != 3'h7);
                            idle_cnt_r <= 8'h00;
                        end else if (idle_cnt_r != idle_len) begin
                            idle_cnt_r <= idle_cnt_r + 8'h01;
                            idle_evt_r <= (idle_cnt_r == idle_len - 8'h01);
                        end
                    end
                    default: begin
                        scnt_r <= scnt_r + 4'h1;
                        if (scnt_r == S8 || scnt_r == S9 || scnt_r == S10) begin
                            smp_r <= {smp_r[1:0], rxd};
                        end
                        if (rx_st_r == RX_START && rxd && (scnt_r == S3 || scnt_r == S5 || scnt_r == S7)) begin
                            edge_bad_r <= 1'b1;
                        end
                        if (scnt_r == SLST) begin
                            case (rx_st_r)
                                RX_START: begin
                                    if (maj) begin
                                        hid_nf_r <= 1'b1;
                                        rx_st_r  <= RX_HUNT;
                                        hist_r   <= 3'h7;
                                    end else begin
                                        nz_r    <= edge_bad_r | (smp_r != 3'h0);
                                        rx_st_r <= RX_DATA;
                                        bcnt_r  <= 4'h0;
                                    end
                                end
                                RX_DATA: begin
                                    sh_r   <= {maj, sh_r[8:1]};
                                    nz_r   <= nz_r | noisy;
                                    bcnt_r <= bcnt_r + 4'h1;
                                    if (bcnt_r == nbits - 4'h1) begin
                                        rx_st_r <= RX_STOP;
                                    end
                                end
                                default: begin
                                    done_r  <= 1'b1;
                                    dfe_r   <= ~maj;
                                    dnf_r   <= nz_r | noisy;
                                    rx_st_r <= RX_HUNT;
                                    hist_r  <= {3{maj}};
                                end
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // receive flags and buffer; a new event beats a same-cycle clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flg_r      <= '0;
            data_r     <= 8'h00;
            r8_r       <= 1'b0;
            idle_arm_r <= 1'b1;
        end else if (ce) begin
            if (rd_dat_clr) begin
                flg_r <= '0;
            end
            if (idle_evt_r && !mute && idle_arm_r) begin
                flg_r.idle <= 1'b1;
                idle_arm_r <= 1'b0;
            end
            if (accept) begin
                if (flg_r.rx_full_flag && !rd_dat_clr) begin
                    flg_r.ovr <= 1'b1; // buffer kept, word dropped
                end else begin
                    data_r     <= rx_word[7:0];
                    r8_r       <= rx_word[8];
                    flg_r.rx_full_flag <= 1'b1;
                    flg_r.fe   <= dfe_r;
                    flg_r.nf   <= dnf_r | hid_nf_r;
                    flg_r.pe   <= parity_enable & (par_of(rx_word, m) != ps);
                    idle_arm_r <= 1'b1;
                end
            end
        end
    end

    // control two; a software write wins over a hardware wake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr2_r <= RST_CTRL;
        end else if (ce) begin
            if (idle_wake || am_wake) begin
                cr2_r[CR2_RWU] <= 1'b0;
            end
            if (wr_cr2) begin
                cr2_r <= pwdata[7:0];
            end
        end
    end

    // transmit tick clock: 16 ticks per bit
    logic [18:0] tx_div;
    logic [18:0] tx_pc_r;
    logic        tx_tick;
    assign tx_div  = div_of(baud_r[BAUD_PR+:2], txfine_r, baud_r[BAUD_TX+:3]);
    assign tx_tick = cr2_r[CR2_TE] & ~scid & (tx_pc_r == 19'h00000);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pc_r <= 19'h00000;
        end else if (ce && !cr2_r[CR2_TE]) begin
            tx_pc_r <= 19'h00000; // restart so a new baud setting ticks at once
        end else if (ce && !scid) begin
            tx_pc_r <= (tx_pc_r == 19'h00000) ? tx_div - 19'h00001 : tx_pc_r - 19'h00001;
        end
    end

    // transmit word with parity in place of the msb
    logic [8:0] tw;
    logic       tx_load;
    always_comb begin
        tw = {cr1_r[CR1_T8], pwdata[7:0]};
        if (parity_enable && m) begin
            tw[8] = par_of(tw & 9'h0FF, 1'b1) ^ ps;
        end else if (parity_enable) begin
            tw[7] = par_of(tw & 9'h07F, 1'b0) ^ ps;
        end
    end
    assign tx_load = wr_dat & cr2_r[CR2_TE] & ~tx_busy_r;

    // transmit shifter; writes while busy are dropped, no holding buffer
    logic [10:0] tx_sh_r;
    logic [3:0]  tx_sub_r;
    logic [3:0]  tx_bits_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_r   <= 11'h7FF;
            tx_sub_r  <= 4'h0;
            tx_bits_r <= 4'h0;
            tx_busy_r <= 1'b0;
            tc_r      <= 1'b1; // nothing pending, so complete out of reset
            txd       <= 1'b1;
        end else if (ce) begin
            txd <= tx_sh_r[0];
            if (wr_dat && sr_seen_r) begin
                tc_r <= 1'b0;
            end
            if (tx_load) begin
                tx_sh_r   <= m ? {1'b1, tw, 1'b0} : {2'h3, tw[7:0], 1'b0};
                tx_bits_r <= m ? FBITS_M1 : FBITS_M0;
                tx_sub_r  <= 4'h0;
                tx_busy_r <= 1'b1;
            end else if (tx_busy_r && tx_tick) begin
                tx_sub_r <= tx_sub_r + 4'h1;
                if (tx_sub_r == SLST) begin
                    tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
                    tx_bits_r <= tx_bits_r - 4'h1;
                    if (tx_bits_r == 4'h1) begin
                        tx_busy_r <= 1'b0;
                        tc_r      <= 1'b1;
                    end
                end
            end
        end
    end

    // single interrupt line; receive sources silenced while muted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= (~mute & ((cr2_r[CR2_RIE] & (flg_r.rx_full_flag | flg_r.ovr)) |
                             (cr2_r[CR2_ILIE] & flg_r.idle) |
                             (cr1_r[CR1_PIE] & flg_r.pe))) |
                   (cr2_r[CR2_TIE] & ~tx_busy_r) | (cr2_r[CR2_TCIE] & tc_r);
        end
    end

    property p_fe_rx_full_flag;
        @(posedge clk) disable iff (!rst_n) $rose(flg_r.fe) |-> flg_r.rx_full_flag && $past(accept);
    endproperty
    a_fe_rx_full_flag: assert property (p_fe_rx_full_flag) else $error("fe rose without a load");

    property p_fe_clear;
        @(posedge clk) disable iff (!rst_n) $fell(flg_r.fe) |-> $past(rd_dat_clr);
    endproperty
    a_fe_clear: assert property (p_fe_clear) else $error("fe cleared without sequence");

    property p_mute_quiet;
        @(posedge clk) disable iff (!rst_n) ce && mute && !am_wake |=> !$rose(flg_r.rx_full_flag) && !$rose(flg_r.idle);
    endproperty
    a_mute_quiet: assert property (p_mute_quiet) else $error("flag set while muted");

    property p_idle_wake;
        @(posedge clk) disable iff (!rst_n) ce && idle_wake && !wr_cr2 |=> !mute && !$rose(flg_r.idle);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

    property p_am_wake;
        @(posedge clk) disable iff (!rst_n) ce && am_wake && !wr_cr2 |=> !mute && flg_r.rx_full_flag;
    endproperty
    a_am_wake: assert property (p_am_wake) else $error("address wake wrong");

    property p_false_start;
        @(posedge clk) disable iff (!rst_n)
            ce && rx_tick && rx_st_r == RX_START && scnt_r == SLST && maj |=> hid_nf_r && rx_st_r == RX_HUNT ##1 !done_r;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start not discarded");

    property p_rx_noise;
        @(posedge clk) disable iff (!rst_n)
            ce && rx_tick && rx_st_r == RX_DATA && scnt_r == SLST && noisy |=> nz_r;
    endproperty
    a_rx_noise: assert property (p_rx_noise) else $error("noise not recorded");

    property p_tick_gap;
        @(posedge clk) disable iff (!rst_n) rx_tick && rx_div > 19'h00001 |=> !rx_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("sample ticks too close");

    property p_tx_par;
        @(posedge clk) disable iff (!rst_n) ce && tx_load && parity_enable && !m |=> (^tx_sh_r[8:1]) == ps && !tx_sh_r[0];
    endproperty
    a_tx_par: assert property (p_tx_par) else $error("transmit parity wrong");
endmodule

// File: urb_pkg.sv
// shared constants and types of the serial receiver / baud block
// assumes a 32-bit APB master and a single 50 MHz clock
package urb_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_BAUD   = 8'h08;
    localparam logic [7:0] ADDR_CR1    = 8'h0C;
    localparam logic [7:0] ADDR_CR2    = 8'h10;
    localparam logic [7:0] ADDR_RXFINE = 8'h14;
    localparam logic [7:0] ADDR_TXFINE = 8'h18;
    // control register one fields
    localparam int CR1_R8   = 7;
    localparam int CR1_T8   = 6;
    localparam int CR1_SCID = 5;
    localparam int CR1_M    = 4;
    localparam int CR1_WAKE = 3;
    localparam int CR1_PCE  = 2;
    localparam int CR1_PS   = 1;
    localparam int CR1_PIE  = 0;
    // control register two fields
    localparam int CR2_TIE  = 7;
    localparam int CR2_TCIE = 6;
    localparam int CR2_RIE  = 5;
    localparam int CR2_ILIE = 4;
    localparam int CR2_TE   = 3;
    localparam int CR2_RE   = 2;
    localparam int CR2_RWU  = 1;
    // baud register fields (lsb positions)
    localparam int BAUD_PR  = 6;
    localparam int BAUD_TX  = 3;
    localparam int BAUD_RX  = 0;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [7:0] RST_FINE = 8'h00;
    // common prescaler divide values
    localparam logic [18:0] PR_0 = 19'h00001;
    localparam logic [18:0] PR_1 = 19'h00003;
    localparam logic [18:0] PR_2 = 19'h00004;
    localparam logic [18:0] PR_3 = 19'h0000D;
    // sample indices within a bit (count of samples already taken)
    localparam logic [3:0] S3   = 4'h2;
    localparam logic [3:0] S5   = 4'h4;
    localparam logic [3:0] S7   = 4'h6;
    localparam logic [3:0] S8   = 4'h7;
    localparam logic [3:0] S9   = 4'h8;
    localparam logic [3:0] S10  = 4'h9;
    localparam logic [3:0] SLST = 4'hF;
    // frame sizes
    localparam logic [3:0] DBITS_M0 = 4'h8;
    localparam logic [3:0] DBITS_M1 = 4'h9;
    localparam logic [3:0] FBITS_M0 = 4'hA;
    localparam logic [3:0] FBITS_M1 = 4'hB;
    localparam logic [7:0] IDLE_M0  = 8'hA0;
    localparam logic [7:0] IDLE_M1  = 8'hB0;

    typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} urb_rxst_type;

    typedef struct packed {
        logic rx_full_flag;
        logic idle;
        logic ovr;
        logic nf;
        logic fe;
        logic pe;
    } urb_flags_type;
endpackage

// File: urb_peer.sv
// serial peer model: a remote transmitter driving the receive line
// assumes send is entered just after a rising clk edge
`timescale 1ns/10ps
module urb_peer (
    // clock and line
    input  wire logic clk,
    output logic      rxd
);
    // line idles high between frames, as a pulled-up line would
    initial rxd = 1'h1;

    // start low, data lsb first, then stop; each bit held per clocks
    task automatic send(input logic [9:0] frm, input int per);
        for (int i = 0; i < 10; i++) begin
            rxd <= frm[i];
            repeat (per) @(posedge clk);
        end
        rxd <= 1'h1;
    endtask
endmodule

// File: testbench.sv
// self-checking bench for the serial receiver block
// assumes the apb answer timing and register map of urb_pkg
`timescale 1ns/10ps
module testbench;
    import urb_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, rxd, txd, pready, pslverr, irq, e;
    logic [7:0]  paddr, d;
    logic [31:0] pwdata, prdata, q, x;
    int          n_fail = 0, n_checks = 0, cyc = 0;
    // case table: baud, rx fine, ctrl one, stop bit
    int          cb[6] = '{'h00, 'h00, 'h41, 'hC0, 'h00, 'h00};
    int          cf[6] = '{0, 0, 0, 2, 0, 0};
    int          cc[6] = '{'h00, 'h00, 'h00, 'h00, 'h05, 'h07};
    int          cs[6] = '{1, 0, 1, 1, 1, 1};

    urb_sci urb_sci_i (.clk(clk), .rst_n(rst_n), .ce(1'h1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    urb_peer urb_peer_i (.clk(clk), .rxd(rxd));

    // 50 MHz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // hang guard, well above the longest baud case
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; the leading edge keeps back-to-back psel writes apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1); // only the cycle guard ends a hung wait
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    // clocks per bit from the baud settings
    function automatic int bit_clks(input int b, input int f);
        int pr[4] = '{1, 3, 4, 13};
        return 16 * pr[b >> 6] * (f != 0 ? f : 1) * (1 << (b & 7));
    endfunction

    task automatic frame(input logic [7:0] v, input logic stp, input int per);
        // a few idle samples first so the start edge counts as valid
        repeat (per / 4) @(posedge clk);
        urb_peer_i.send({stp, v, 1'h0}, per);
        repeat (4) @(posedge clk);
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(69));
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            // parity bit in the msb; case 4 is sent deliberately wrong
            if (cc[i][2]) d[7] = ^d[6:0] ^ cc[i][1] ^ (i == 4);
            apb(1'h1, ADDR_CR2, 8'h00, q, e);
            apb(1'h1, ADDR_BAUD, cb[i][7:0], q, e);
            apb(1'h1, ADDR_RXFINE, cf[i][7:0], q, e);
            apb(1'h1, ADDR_CR1, cc[i][7:0], q, e);
            apb(1'h1, ADDR_CR2, 8'h04, q, e);
            frame(d, cs[i][0], bit_clks(cb[i], cf[i]));
            x = 32'hE0 | (cs[i] != 0 ? 0 : 2) | (i == 4);
            apb(1'h0, ADDR_STATUS, 8'h00, q, e);
            chk(q, x);
            chk(irq, i == 4);
            apb(1'h0, ADDR_DATA, 8'h00, q, e);
            chk(q, d);
            apb(1'h0, ADDR_STATUS, 8'h00, q, e);
            chk(q, 32'hC0);
        end
        // short start pulse is dropped; its noise shows with the next word
        apb(1'h1, ADDR_CR1, 8'h08, q, e);
        frame(8'hFF, 1'h1, 8);
        d = $urandom;
        frame(d, 1'h1, 16);
        apb(1'h0, ADDR_STATUS, 8'h00, q, e);
        chk(q, 32'hE4);
        apb(1'h0, ADDR_DATA, 8'h00, q, e);
        chk(q, d);
        // mute with address-mark wake; no control two write until woken
        apb(1'h1, ADDR_CR2, 8'h06, q, e);
        frame(8'h55, 1'h1, 16);
        apb(1'h0, ADDR_STATUS, 8'h00, q, e);
        chk(q, 32'hC0);
        d = $urandom;
        d[7] = 1'h1;
        frame(d, 1'h1, 16);
        apb(1'h0, ADDR_STATUS, 8'h00, q, e);
        chk(q, 32'hE0);
        apb(1'h0, ADDR_CR2, 8'h00, q, e);
        chk(q, 32'h04);
        apb(1'h0, ADDR_DATA, 8'h00, q, e);
        chk(q, d);
        // idle-line wake clears the mute bit and leaves the idle flag low
        apb(1'h1, ADDR_CR1, 8'h00, q, e);
        apb(1'h1, ADDR_CR2, 8'h06, q, e);
        repeat (200) @(posedge clk);
        apb(1'h0, ADDR_CR2, 8'h00, q, e);
        chk(q, 32'h04);
        apb(1'h0, ADDR_STATUS, 8'h00, q, e);
        chk(q, 32'hC0);
        // odd parity replaces the top data bit on the transmit line
        apb(1'h1, ADDR_CR1, 8'h06, q, e);
        apb(1'h1, ADDR_CR2, 8'h08, q, e);
        d = $urandom;
        apb(1'h1, ADDR_DATA, d, q, e);
        x = {22'h0, 1'h1, ~^d[6:0], d[6:0], 1'h0};
        repeat (9) @(posedge clk);
        for (int k = 0; k < 10; k++) begin
            chk(txd, x[k]);
            repeat (16) @(posedge clk);
        end
        // unmapped address reads zero with an error response
        apb(1'h0, 8'h1C, 8'h00, q, e);
        chk({q, e}, 33'h1);
        report_and_stop();
    end
endmodule
